//--- rtl/dsl_pkg.sv
// Shared constants and types for the display sync and layer control block
package dsl_pkg;
   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] DMC2_ADDR = 9'h056;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   localparam int BIT_PRI_HI = 11;
   localparam int BIT_ODD_POL = 8;
   localparam int BIT_CS_HI = 7;
   localparam int BIT_CS_LO = 6;
   localparam int BIT_PRI_LO = 5;
   localparam int BIT_FG_HIDE = 3;
   localparam int BIT_CUR2 = 2;

   // ----------------------------------------------------------------
   // Mode encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] CS_XOR = 2'h0;
   localparam logic [1:0] CS_EQ3 = 2'h2;
   localparam logic [1:0] CS_EQ25 = 2'h3;
   localparam logic [1:0] TV_MASTER = 2'h0;
   localparam logic [1:0] PRI_CUR_TOP = 2'h0;
   localparam logic [1:0] PRI_CUR2_LOW = 2'h2;
   localparam logic [1:0] PRI_FG_TOP = 2'h3;

   // ----------------------------------------------------------------
   // Vertical sync interval, counted in half rasters
   // ----------------------------------------------------------------
   localparam int HALF_W = 5;
   localparam int DOT_W = 12;
   localparam logic [HALF_W-1:0] EQ3_START = 5'h00;
   localparam logic [HALF_W-1:0] SERR3_START = 5'h06;
   localparam logic [HALF_W-1:0] EQ3B_START = 5'h0c;
   localparam logic [HALF_W-1:0] EQ3_END = 5'h12;
   localparam logic [HALF_W-1:0] EQ25_START = 5'h01;
   localparam logic [HALF_W-1:0] SERR25_START = 5'h06;
   localparam logic [HALF_W-1:0] EQ25B_START = 5'h0b;
   localparam logic [HALF_W-1:0] EQ25_END = 5'h10;
   localparam logic [DOT_W-1:0] DOT_ONE = 12'h001;

   typedef enum logic [2:0] {
      LAYER_BG,
      LAYER_VIDEO,
      LAYER_FG,
      LAYER_CUR1,
      LAYER_CUR2
   } dsl_layer_t;
endpackage : dsl_pkg

//--- rtl/dsl_sync_if.sv
// Carrier between the control top and the composite sync generator
`timescale 1ns/1ps
interface dsl_sync_if;
   logic [1:0] csMode;
   logic master;
   logic [dsl_pkg::DOT_W-1:0] rasterLen;
   logic [dsl_pkg::DOT_W-1:0] eqWidth;
   logic [dsl_pkg::DOT_W-1:0] serrWidth;
   logic hsyncN;
   logic vsyncN;
   logic csyncVal;
   modport gen (input csMode, master, rasterLen, eqWidth, serrWidth, hsyncN, vsyncN, output csyncVal);
   modport ctl (output csMode, master, rasterLen, eqWidth, serrWidth, hsyncN, vsyncN, input csyncVal);
endinterface : dsl_sync_if

//--- rtl/dsl_composite_sync_gen.sv
// Composite sync waveform generator with equalizing and serration phases
`timescale 1ns/1ps
module dsl_composite_sync_gen (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clkEn,
   // Settings and sync timing
   dsl_sync_if.gen sync
);
   logic vsyncPrev_ff;
   logic running_ff;
   logic [dsl_pkg::HALF_W-1:0] halfIdx_ff;
   logic [dsl_pkg::DOT_W-1:0] dot_ff;
   logic [dsl_pkg::DOT_W-1:0] halfLen;
   logic vsFall;
   logic eqLow;
   logic serrLow;

   function automatic logic inWin(input logic [dsl_pkg::HALF_W-1:0] idx,
                                  input logic [dsl_pkg::HALF_W-1:0] lo,
                                  input logic [dsl_pkg::HALF_W-1:0] hi);
      inWin = (idx >= lo) && (idx < hi);
   endfunction : inWin

   assign halfLen = sync.rasterLen >> 1;
   assign vsFall = vsyncPrev_ff & ~sync.vsyncN;
   assign eqLow = dot_ff < sync.eqWidth;
   // Serration stays low except its final high slot
   assign serrLow = (sync.serrWidth < halfLen) && (dot_ff < (halfLen - sync.serrWidth));

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         vsyncPrev_ff <= 1'b1;
      end else if (clkEn) begin
         vsyncPrev_ff <= sync.vsyncN;
      end
   end

   // RQ15: Half raster count
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         running_ff <= 1'b0;
         halfIdx_ff <= '0;
         dot_ff <= '0;
      end else if (clkEn) begin
         if (vsFall) begin
            running_ff <= 1'b1;
            halfIdx_ff <= '0;
            dot_ff <= '0;
         end else if (running_ff) begin
            if (dot_ff + dsl_pkg::DOT_ONE >= halfLen) begin
               dot_ff <= '0;
               if (halfIdx_ff == dsl_pkg::EQ3_END) begin
                  running_ff <= 1'b0;
               end else begin
                  halfIdx_ff <= halfIdx_ff + 5'h01;
               end
            end else begin
               dot_ff <= dot_ff + dsl_pkg::DOT_ONE;
            end
         end
      end
   end

   always_comb begin
      sync.csyncVal = sync.hsyncN;
      // RQ3: XOR of syncs
      if (!sync.master || sync.csMode[1] == 1'b0) begin
         sync.csyncVal = sync.vsyncN ^ sync.hsyncN;
      end else if (running_ff && sync.csMode == dsl_pkg::CS_EQ3) begin
         // RQ6: Three raster phases
         if (inWin(halfIdx_ff, dsl_pkg::EQ3_START, dsl_pkg::SERR3_START)) begin
            sync.csyncVal = ~eqLow;
         end else if (inWin(halfIdx_ff, dsl_pkg::SERR3_START, dsl_pkg::EQ3B_START)) begin
            sync.csyncVal = ~serrLow;
         end else if (inWin(halfIdx_ff, dsl_pkg::EQ3B_START, dsl_pkg::EQ3_END)) begin
            sync.csyncVal = ~eqLow;
         end
      end else if (running_ff) begin
         // RQ7: Offset half raster phases
         if (inWin(halfIdx_ff, dsl_pkg::EQ25_START, dsl_pkg::SERR25_START)) begin
            sync.csyncVal = ~eqLow;
         end else if (inWin(halfIdx_ff, dsl_pkg::SERR25_START, dsl_pkg::EQ25B_START)) begin
            sync.csyncVal = ~serrLow;
         end else if (inWin(halfIdx_ff, dsl_pkg::EQ25B_START, dsl_pkg::EQ25_END)) begin
            sync.csyncVal = ~eqLow;
         end
      end
   end

   a_eq3_pulse: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
      (sync.master && sync.csMode == dsl_pkg::CS_EQ3 && running_ff && halfIdx_ff < dsl_pkg::SERR3_START && eqLow)
      |-> !sync.csyncVal)
      else $error("equalizing pulse missing in three raster mode");
   a_eq25_delay: assert property (@(posedge clock) disable iff (!rst_n) // RQ7
      (sync.master && sync.csMode == dsl_pkg::CS_EQ25 && running_ff && halfIdx_ff < dsl_pkg::EQ25_START)
      |-> sync.csyncVal == sync.hsyncN)
      else $error("first half raster must carry horizontal sync");
   a_count_start: assert property (@(posedge clock) disable iff (!rst_n) // RQ15
      (clkEn && vsFall) |=> (running_ff && halfIdx_ff == '0 && dot_ff == '0))
      else $error("half raster count not restarted at vertical sync fall");
endmodule : dsl_composite_sync_gen

//--- rtl/dsl_top.sv
// Display sync and layer control: mode register, odd field, composite sync, layer select
//
// Overview of operation
// RQ1: Odd field flag low in first field when polarity 0, high when 1; the code holds it low whenever interlaceOn is low.
// RQ2: Composite sync mode field acts only when both TV mode bits are zero.
// RQ3: Mode 00 outputs XOR of active-low vertical and horizontal sync.
// RQ4: Software picks mode 00 while TV sync mode is active.
// RQ5: Software never writes composite sync mode 01.
// RQ6: Mode 10: three rasters equalizing, serration, equalizing from vertical sync fall.
// RQ7: Mode 11: after half raster, 2.5 rasters each of equalizing, serration, equalizing.
// RQ8: Software sets equalizing and serration widths before using modes 1x.
// RQ9: Priority field orders cursor, foreground, video and background planes.
// RQ10: Software writes zero to reserved bit 4.
// RQ11: Foreground hide bit set suppresses the foreground screen.
// RQ12: Cursor 2 enable bit shows or hides cursor 2.
// RQ13: Reset keeps composite sync mode bits and clears the rest.
// RQ14: Enabled cursor 2 always blinks between its two shapes.
// RQ15: Pulse phases counted in half rasters from vertical sync fall.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module dsl_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clkEn,
   // Register port
   input wire logic [dsl_pkg::ADDR_W-1:0] regAddr,
   input wire logic [dsl_pkg::DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [dsl_pkg::DATA_W-1:0] regRdData_ff,
   // Display timing, same clock
   input wire logic hsyncN,
   input wire logic vsyncN,
   input wire logic interlaceOn,
   input wire logic firstField,
   input wire logic tvModeHi,
   input wire logic tvModeLo,
   input wire logic [dsl_pkg::DOT_W-1:0] rasterLen,
   input wire logic [dsl_pkg::DOT_W-1:0] equalizingWidth,
   input wire logic [dsl_pkg::DOT_W-1:0] serrationWidth,
   // Plane presence at current pixel
   input wire logic cur1Present,
   input wire logic cur2ShapeA,
   input wire logic cur2ShapeB,
   input wire logic blinkPhase,
   input wire logic fgPresent,
   input wire logic videoPresent,
   // Display outputs
   output logic oddFieldFlag_ff,
   output logic compositeSyncN_ff,
   output dsl_pkg::dsl_layer_t layerSel_ff
);
   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic oddPol_ff;
   logic [1:0] csMode_ff;
   // Unknown until the first write, so the reset check skips the power-up value
   logic csKnown_ff;
   logic priHi_ff;
   logic priLo_ff;
   logic fgHide_ff;
   logic cur2Show_ff;
   logic [1:0] priCode;
   logic cur2Vis;
   logic [dsl_pkg::DATA_W-1:0] rdWord;
   logic hitReg;
   dsl_sync_if syncBus ();

   function automatic dsl_pkg::dsl_layer_t pickLayer(input logic [1:0] layer_priority_lo, input logic c1, input logic c2,
                                                     input logic fg, input logic vid);
      pickLayer = dsl_pkg::LAYER_BG;
      case (layer_priority_lo)
         dsl_pkg::PRI_CUR2_LOW: begin
            if (c1) pickLayer = dsl_pkg::LAYER_CUR1;
            else if (fg) pickLayer = dsl_pkg::LAYER_FG;
            else if (vid) pickLayer = dsl_pkg::LAYER_VIDEO;
            else if (c2) pickLayer = dsl_pkg::LAYER_CUR2;
         end
         dsl_pkg::PRI_FG_TOP: begin
            if (fg) pickLayer = dsl_pkg::LAYER_FG;
            else if (vid) pickLayer = dsl_pkg::LAYER_VIDEO;
            else if (c1) pickLayer = dsl_pkg::LAYER_CUR1;
            else if (c2) pickLayer = dsl_pkg::LAYER_CUR2;
         end
         default: begin
            // Prohibited code falls back to the cursor-on-top order
            if (c1) pickLayer = dsl_pkg::LAYER_CUR1;
            else if (c2) pickLayer = dsl_pkg::LAYER_CUR2;
            else if (fg) pickLayer = dsl_pkg::LAYER_FG;
            else if (vid) pickLayer = dsl_pkg::LAYER_VIDEO;
         end
      endcase
   endfunction : pickLayer

   assign hitReg = (regAddr == dsl_pkg::DMC2_ADDR);
   assign priCode = {priHi_ff, priLo_ff};

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // RQ13: Cleared fields
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         oddPol_ff <= 1'b0;
         priHi_ff <= 1'b0;
         priLo_ff <= 1'b0;
         fgHide_ff <= 1'b0;
         cur2Show_ff <= 1'b0;
      end else if (clkEn && regWr && hitReg) begin
         oddPol_ff <= regWrData[dsl_pkg::BIT_ODD_POL];
         priHi_ff <= regWrData[dsl_pkg::BIT_PRI_HI];
         priLo_ff <= regWrData[dsl_pkg::BIT_PRI_LO];
         fgHide_ff <= regWrData[dsl_pkg::BIT_FG_HIDE];
         cur2Show_ff <= regWrData[dsl_pkg::BIT_CUR2];
      end
   end

   // RQ13: Sync mode survives reset
   always_ff @(posedge clock) begin
      if (rst_n && clkEn && regWr && hitReg) begin
         csMode_ff <= {regWrData[dsl_pkg::BIT_CS_HI], regWrData[dsl_pkg::BIT_CS_LO]};
         csKnown_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   always_comb begin
      rdWord = dsl_pkg::DATA_ZERO;
      rdWord[dsl_pkg::BIT_PRI_HI] = priHi_ff;
      rdWord[dsl_pkg::BIT_ODD_POL] = oddPol_ff;
      rdWord[dsl_pkg::BIT_CS_HI] = csMode_ff[1];
      rdWord[dsl_pkg::BIT_CS_LO] = csMode_ff[0];
      rdWord[dsl_pkg::BIT_PRI_LO] = priLo_ff;
      rdWord[dsl_pkg::BIT_FG_HIDE] = fgHide_ff;
      rdWord[dsl_pkg::BIT_CUR2] = cur2Show_ff;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         regRdData_ff <= dsl_pkg::DATA_ZERO;
      end else if (clkEn) begin
         if (regRd && hitReg) begin
            regRdData_ff <= rdWord;
         end else begin
            regRdData_ff <= dsl_pkg::DATA_ZERO;
         end
      end
   end

   // ----------------------------------------------------------------
   // Odd field flag
   // ----------------------------------------------------------------
   // RQ1: Polarity select
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         oddFieldFlag_ff <= 1'b0;
      end else if (clkEn) begin
         oddFieldFlag_ff <= interlaceOn & (firstField ~^ oddPol_ff);
      end
   end

   // ----------------------------------------------------------------
   // Composite sync
   // ----------------------------------------------------------------
   // RQ2: Master mode gate
   assign syncBus.master = ({tvModeHi, tvModeLo} == dsl_pkg::TV_MASTER);
   assign syncBus.csMode = csMode_ff;
   assign syncBus.rasterLen = rasterLen;
   assign syncBus.eqWidth = equalizingWidth;
   assign syncBus.serrWidth = serrationWidth;
   assign syncBus.hsyncN = hsyncN;
   assign syncBus.vsyncN = vsyncN;

   dsl_composite_sync_gen csyncGen (
      .clock(clock),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .sync(syncBus.gen)
   );

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         compositeSyncN_ff <= 1'b1;
      end else if (clkEn) begin
         compositeSyncN_ff <= syncBus.csyncVal;
      end
   end

   // ----------------------------------------------------------------
   // Layer selection
   // ----------------------------------------------------------------
   // RQ12: Cursor 2 enable
   // RQ14: Blink between shapes
   assign cur2Vis = cur2Show_ff & (blinkPhase ? cur2ShapeB : cur2ShapeA);

   // RQ9: Ordered plane pick
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         layerSel_ff <= dsl_pkg::LAYER_BG;
      end else if (clkEn) begin
         // RQ11: Foreground hide
         layerSel_ff <= pickLayer(priCode, cur1Present, cur2Vis, fgPresent & ~fgHide_ff, videoPresent);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_odd_field_pol: assert property (@(posedge clock) disable iff (!rst_n) // RQ1
      (clkEn && interlaceOn && firstField) |=> (oddFieldFlag_ff == $past(oddPol_ff)))
      else $error("odd field flag polarity wrong in first field");
   a_composite_sync_slave: assert property (@(posedge clock) disable iff (!rst_n) // RQ2
      (clkEn && !syncBus.master) |=> (compositeSyncN_ff == $past(vsyncN ^ hsyncN)))
      else $error("composite sync must be XOR outside master mode");
   a_composite_sync_xor: assert property (@(posedge clock) disable iff (!rst_n) // RQ3
      (clkEn && csMode_ff == dsl_pkg::CS_XOR) |=> (compositeSyncN_ff == $past(vsyncN ^ hsyncN)))
      else $error("mode 00 composite sync is not the XOR of the syncs");
   a_fg_top_order: assert property (@(posedge clock) disable iff (!rst_n) // RQ9
      (clkEn && priCode == dsl_pkg::PRI_FG_TOP && fgPresent && !fgHide_ff)
      |=> layerSel_ff == dsl_pkg::LAYER_FG)
      else $error("foreground must win in foreground-top order");
   a_fg_hidden: assert property (@(posedge clock) disable iff (!rst_n) // RQ11
      (clkEn && fgHide_ff) |=> layerSel_ff != dsl_pkg::LAYER_FG)
      else $error("hidden foreground was selected");
   a_cur2_hidden: assert property (@(posedge clock) disable iff (!rst_n) // RQ12
      (clkEn && !cur2Show_ff) |=> layerSel_ff != dsl_pkg::LAYER_CUR2)
      else $error("disabled cursor 2 was selected");
   a_cur2_blink: assert property (@(posedge clock) disable iff (!rst_n) // RQ14
      (clkEn && cur2Show_ff && priCode == dsl_pkg::PRI_CUR_TOP && !cur1Present && blinkPhase && cur2ShapeB)
      |=> layerSel_ff == dsl_pkg::LAYER_CUR2)
      else $error("cursor 2 shape B not shown in its blink phase");
   a_reset_fields: assert property (@(posedge clock) // RQ13
      !rst_n |=> (!oddPol_ff && !priHi_ff && !priLo_ff && !fgHide_ff && !cur2Show_ff))
      else $error("reset must clear the non-sync fields");
   a_csmode_kept: assert property (@(posedge clock) // RQ13
      (!rst_n && csKnown_ff) |=> (csMode_ff == $past(csMode_ff)))
      else $error("reset must keep the sync mode bits");
endmodule : dsl_top

//--- bench/dsl_raster_src.sv
// Raster timing source standing in for the far side sync timing
`timescale 1ns/1ps
module dsl_raster_src #(
   parameter int RL = 40,
   parameter int NL = 14,
   parameter int VL = 3,
   parameter int HW = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Sync levels and current raster position
   output logic hsyncN,
   output logic vsyncN,
   output int lineIdx_ff,
   output int dotIdx_ff
);
   // ----------------------------------------------------------------
   // Dot and line counters
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n || dotIdx_ff == RL - 1)
         dotIdx_ff <= 0;
      else
         dotIdx_ff <= dotIdx_ff + 1;
   end

   always_ff @(posedge clock) begin
      if (!rst_n)
         lineIdx_ff <= 0;
      else if (dotIdx_ff == RL - 1)
         lineIdx_ff <= (lineIdx_ff == NL - 1) ? 0 : lineIdx_ff + 1;
   end

   // Sync falls at line and frame start, so one frame holds every pulse phase
   assign hsyncN = !(dotIdx_ff < HW);
   assign vsyncN = !(lineIdx_ff < VL);
endmodule : dsl_raster_src

//--- bench/tb.sv
// Self-checking bench for the display sync and layer control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin badCount++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
   localparam int RL = 40;
   localparam int NL = 14;
   localparam int HALF = RL / 2;
   localparam int EQW = 2;
   localparam int SW = 3;
   logic clock, rst_n, clkEn, regWr, regRd, interlaceOn, firstField, tvModeHi, tvModeLo;
   logic [dsl_pkg::ADDR_W-1:0] regAddr;
   logic [dsl_pkg::DATA_W-1:0] regWrData, regRdData_ff;
   logic [dsl_pkg::DOT_W-1:0] rasterLen, equalizingWidth, serrationWidth;
   logic [5:0] planes;
   logic hsyncN, vsyncN, oddFieldFlag_ff, compositeSyncN_ff, syncChk, exp1, curHide, curC2;
   logic [1:0] csMode, curPri;
   dsl_pkg::dsl_layer_t layerSel_ff;
   int badCount, testsRun, lineIdx, dotIdx;
   logic [1:0] priCodes [3] = '{2'h0, 2'h2, 2'h3};

   dsl_top i_dsl_top (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData_ff),
      .hsyncN(hsyncN), .vsyncN(vsyncN), .interlaceOn(interlaceOn), .firstField(firstField),
      .tvModeHi(tvModeHi), .tvModeLo(tvModeLo), .rasterLen(rasterLen),
      .equalizingWidth(equalizingWidth), .serrationWidth(serrationWidth),
      .cur1Present(planes[5]), .cur2ShapeA(planes[4]), .cur2ShapeB(planes[3]),
      .blinkPhase(planes[2]), .fgPresent(planes[1]), .videoPresent(planes[0]),
      .oddFieldFlag_ff(oddFieldFlag_ff), .compositeSyncN_ff(compositeSyncN_ff),
      .layerSel_ff(layerSel_ff));
   dsl_raster_src #(.RL(RL), .NL(NL)) i_dsl_raster_src (.clock(clock), .rst_n(rst_n),
      .hsyncN(hsyncN), .vsyncN(vsyncN), .lineIdx_ff(lineIdx), .dotIdx_ff(dotIdx));

   always #2.5 clock = ~clock;

   // ----------------------------------------------------------------
   // Expected values
   // ----------------------------------------------------------------
   function automatic logic [15:0] word(input logic [1:0] p, input logic pol, input logic [1:0] cs,
                                        input logic hide, input logic c2);
      word = {4'h0, p[1], 2'h0, pol, cs, p[0], 1'b0, hide, c2, 2'h0};
   endfunction : word

   function automatic logic calc(input int q, input logic vs, input logic hs);
      int k;
      int h;
      int d;
      logic eq;
      logic sr;
      k = q - 1;
      h = k / HALF;
      d = k % HALF;
      eq = csMode[0] ? ((h >= 1 && h < 6) || (h >= 11 && h < 16)) : (h < 6 || (h >= 12 && h < 18));
      sr = csMode[0] ? (h >= 6 && h < 11) : (h >= 6 && h < 12);
      calc = hs;
      if (tvModeHi || tvModeLo || !csMode[1])
         calc = vs ^ hs;
      else if (k >= 0 && eq)
         calc = (d >= EQW);
      else if (k >= 0 && sr)
         calc = (d >= HALF - SW);
   endfunction : calc

   // Planes listed lowest first, so each later test overrides the earlier
   function automatic dsl_pkg::dsl_layer_t lay(input logic [5:0] v);
      logic c2;
      logic fg;
      c2 = curC2 && (v[2] ? v[3] : v[4]);
      fg = v[1] && !curHide;
      lay = dsl_pkg::LAYER_BG;
      if (curPri == 2'h2 && c2) lay = dsl_pkg::LAYER_CUR2;
      if (curPri == 2'h3 && c2) lay = dsl_pkg::LAYER_CUR2;
      if (curPri == 2'h3 && v[5]) lay = dsl_pkg::LAYER_CUR1;
      if (v[0]) lay = dsl_pkg::LAYER_VIDEO;
      if (fg) lay = dsl_pkg::LAYER_FG;
      if (curPri == 2'h0 && c2) lay = dsl_pkg::LAYER_CUR2;
      if (curPri != 2'h3 && v[5]) lay = dsl_pkg::LAYER_CUR1;
   endfunction : lay

   // ----------------------------------------------------------------
   // Register port tasks
   // ----------------------------------------------------------------
   task wr(input logic [dsl_pkg::ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
   endtask : wr

   task rd(input logic [dsl_pkg::ADDR_W-1:0] a, input logic [15:0] e);
      @(posedge clock);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      #1;
      `CHK("readback", e, regRdData_ff)
   endtask : rd

   task syncRun(input logic [1:0] m, input logic h, input logic l);
      syncChk = 1'b0;
      wr(dsl_pkg::DMC2_ADDR, word(2'h0, 1'b0, m, 1'b0, 1'b0));
      csMode = m;
      tvModeHi <= h;
      tvModeLo <= l;
      repeat (4) @(posedge clock);
      while (!(lineIdx == NL - 1 && dotIdx == RL - 1)) @(posedge clock);
      syncChk = 1'b1;
      repeat (2 * NL * RL) @(posedge clock);
      syncChk = 1'b0;
   endtask : syncRun

   task endSim();
      if (badCount == 0 && testsRun > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : endSim

   // ----------------------------------------------------------------
   // Composite sync watcher, one stage like the registered output
   // ----------------------------------------------------------------
   always @(posedge clock) begin
      exp1 <= calc(lineIdx * RL + dotIdx, vsyncN, hsyncN);
   end
   always @(negedge clock) begin
      if (syncChk) `CHK("composite_sync", exp1, compositeSyncN_ff)
   end

   initial begin
      #200000;
      badCount++;
      endSim();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      {clock, regWr, regRd, interlaceOn, firstField, tvModeHi, tvModeLo, syncChk} = '0;
      {regAddr, regWrData, planes, csMode, curPri, curHide, curC2} = '0;
      {badCount, testsRun} = '0;
      rst_n = 1'b0;
      clkEn = 1'b1;
      rasterLen = 12'(RL);
      // Widths set before any pulse mode is chosen
      equalizingWidth = 12'(EQW);
      serrationWidth = 12'(SW);
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      wr(dsl_pkg::DMC2_ADDR, 16'h0fef);
      rd(dsl_pkg::DMC2_ADDR, word(2'h3, 1'b1, 2'h3, 1'b1, 1'b1));
      wr(9'h057, 16'h0000);
      rd(dsl_pkg::DMC2_ADDR, 16'h09ec);
      rd(9'h057, 16'h0000);
      // Strobe while the clock enable is low must be dropped
      clkEn <= 1'b0;
      wr(dsl_pkg::DMC2_ADDR, 16'h0000);
      clkEn <= 1'b1;
      rd(dsl_pkg::DMC2_ADDR, 16'h09ec);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rd(dsl_pkg::DMC2_ADDR, 16'h00c0);
      for (int i = 0; i < 8; i++) begin
         wr(dsl_pkg::DMC2_ADDR, word(2'h0, i[0], 2'h0, 1'b0, 1'b0));
         interlaceOn <= i[1];
         firstField <= i[2];
         repeat (2) @(posedge clock);
         #1;
         `CHK("odd flag", i[1] & (i[0] ~^ i[2]), oddFieldFlag_ff)
      end
      for (int c = 0; c < 12; c++) begin
         curPri = priCodes[c % 3];
         curHide = (c / 3) % 2;
         curC2 = c / 6;
         wr(dsl_pkg::DMC2_ADDR, word(curPri, 1'b0, 2'h0, curHide, curC2));
         for (int v = 0; v < 64; v++) begin
            planes <= 6'(v);
            repeat (2) @(posedge clock);
            #1;
            `CHK("layer", lay(6'(v)), layerSel_ff)
         end
      end
      syncRun(2'h0, 1'b0, 1'b0);
      syncRun(2'h2, 1'b0, 1'b0);
      syncRun(2'h3, 1'b0, 1'b0);
      syncRun(2'h0, 1'b1, 1'b0);
      syncRun(2'h3, 1'b0, 1'b1);
      syncRun(2'h2, 1'b1, 1'b1);
      endSim();
   end
endmodule : tb
